/* File: design/wdr_params.svh */
`ifndef WDR_PARAMS_SVH
`define WDR_PARAMS_SVH

// core clock and reset pulse timing
`define WDR_CLK_PERIOD_PS   8000
`define WDR_HALF_PER_PS     4000
`define WDR_FILTER_NS       500
`define WDR_LONG_HALF       (1032 + 12)
`define WDR_HOLD_HALF       1032

`define WDR_MIN_PULSE_PS    (((4 * `WDR_HALF_PER_PS) > (`WDR_FILTER_NS * 1000)) ? \
                             (4 * `WDR_HALF_PER_PS) : (`WDR_FILTER_NS * 1000))
`define WDR_SHORT_CYC       ((`WDR_MIN_PULSE_PS + `WDR_CLK_PERIOD_PS - 1) / `WDR_CLK_PERIOD_PS)
`define WDR_LONG_CYC        (((`WDR_LONG_HALF * `WDR_HALF_PER_PS) + `WDR_MIN_PULSE_PS + \
                              `WDR_CLK_PERIOD_PS - 1) / `WDR_CLK_PERIOD_PS)
`define WDR_HOLD_CYC        ((`WDR_HOLD_HALF * `WDR_HALF_PER_PS) / `WDR_CLK_PERIOD_PS)

// prescaler divide ratios
`define WDR_DIV_FAST        2
`define WDR_DIV_SLOW        128

// counter layout and reset values
`define WDR_COUNT_RESET     16'h0000
`define WDR_COUNT_MAX       16'hffff
`define WDR_LOW_BYTE_CLR    8'h00

`endif

/* File: design/wdr_pkg.sv */
package wdr_pkg;

   typedef struct packed {
      logic powerOn;
      logic longHw;
      logic shortHw;
      logic watchdog;
      logic software;
   } wdr_flags_t;

   typedef enum logic [1:0] {PH_RUN, PH_HOLD, PH_PINLOW} wdr_phase_t;

   typedef struct packed {
      wdr_phase_t  phase;
      logic [15:0] count;
      logic        running;
      logic        initDone;
      wdr_flags_t  flags;
      logic [9:0]  holdCnt;
      logic [10:0] lowCnt;
      logic        rstSync1;
      logic        rstSync2;
      logic        pwrDnSync1;
      logic        pwrDnSync2;
      logic [2:0]  drvDly;
      logic        outN;
      logic        pinOe;
      logic        pinOut;
      logic        chipReset;
   } wdr_state_t;

   typedef struct packed {
      logic [6:0] div;
      logic       tick;
   } wdr_presc_state_t;

endpackage : wdr_pkg

/* File: design/wdr_prescaler.sv */
`timescale 1ns/1ns
`include "wdr_params.svh"

module wdr_prescaler (
   input  wire logic core_clk, // system clock
   input  wire logic rst_n,    // async reset, active low
   input  wire logic clkEn,    // freezes state while low
   input  wire logic clear,    // restart division from zero
   input  wire logic divSel,   // 0: divide by 2, 1: divide by 128
   output logic      tick      // one-cycle pulse per prescaled period
);

   wdr_pkg::wdr_presc_state_t s;
   wdr_pkg::wdr_presc_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (clear) begin
         next_s.div = 7'h00;
      end else if (divSel) begin
         next_s.div = s.div + 7'h01;
         // tick is registered, so flag it one count early to keep a 128-cycle period
         next_s.tick = (s.div == 7'(`WDR_DIV_SLOW - 2));
      end else begin
         next_s.div = 7'h00;
         next_s.tick = (s.div == 7'(`WDR_DIV_FAST - 2)) && !s.tick;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else if (clkEn) begin
         s <= next_s;
      end
   end

   assign tick = s.tick;

endmodule : wdr_prescaler

/* File: design/wdr_watchdog.sv */
// Function
// - watchdog counter runs right after every reset, no setup needed.
// - disable accepted only before end of init; ignored afterwards until reset.
// - counter overflow without service triggers an internal chip reset.
// - during watchdog reset the reset output pin is driven low.
// - 16-bit counter clocked by core clock divided by 2 or 128.
// - each service loads counter high byte from the reload byte.
// - timeout spans 256 ticks (reload ff) to 65536 ticks (reload 00).
// - status flags record reset sources seen since the last end of init or power-on reset; async reset sets no flag.
// - counter overflow reset sets the watchdog reset flag.
// - software reset instruction sets the software reset flag.
// - hardware resets set power-on, long or short flag by pulse and pin.
// - power-down pin high: pulse length picks long or short flag.
// - end of init clears all reset-source flags.
// - six reset cases: power-on, async, long, short, watchdog, software.
// - with bidirectional reset, low power-down pin blocks driving reset input.
`timescale 1ns/1ns
`include "wdr_params.svh"

module wdr_watchdog (
   input  wire logic        core_clk,                 // system clock, 125 MHz
   input  wire logic        rst_n,                    // power-on reset, async, active low
   input  wire logic        clkEn,                    // freezes all state while low
   input  wire logic        resetInputPinIn,          // reset input pin level, low = reset
   output logic             resetInputPinOut,         // reset input pin drive value
   output logic             resetInputPinOe,          // reset input pin drive enable
   input  wire logic        resetPowerDownPin,        // reset power-down pin level
   input  wire logic        bidirectionalResetEnable, // drive reset input on sw/wdt reset
   input  wire logic        watchdogPrescaleSelect,   // 0: /2, 1: /128
   input  wire logic [7:0]  watchdogReloadByte,       // reload for counter high byte
   input  wire logic        serviceStrobe,            // service instruction pulse
   input  wire logic        disableStrobe,            // disable instruction pulse
   input  wire logic        endOfInitStrobe,          // end-of-init instruction pulse
   input  wire logic        softwareResetStrobe,      // software reset instruction pulse
   output logic             resetOutputPinN,          // reset output pin, active low
   output logic             chipReset,                // internal hardware reset, active high
   output logic [15:0]      watchdogCount,            // current counter value
   output logic             watchdogRunning,          // counter enabled
   output logic             initDone,                 // end of init has executed
   output wdr_pkg::wdr_flags_t watchdogControlReg     // reset-source flags
);

   wdr_pkg::wdr_state_t s;
   wdr_pkg::wdr_state_t next_s;
   logic                tick;
   logic                presClear;

   // high byte from reload, low byte cleared
   function automatic logic [15:0] reloadValue(input logic [7:0] rel);
      reloadValue = {rel, `WDR_LOW_BYTE_CLR};
   endfunction : reloadValue

   // classify a released external reset pulse into a flag set
   function automatic wdr_pkg::wdr_flags_t classifyPulse(input logic [10:0] len,
                                                         input logic pwrDnHigh);
      classifyPulse = '0;
      if (pwrDnHigh) begin
         if (len > 11'(`WDR_LONG_CYC)) begin
            classifyPulse.longHw = 1'b1;
         end else if (len > 11'(`WDR_SHORT_CYC)) begin
            classifyPulse.shortHw = 1'b1;
         end
      end
   endfunction : classifyPulse

   wdr_prescaler u_presc (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .clkEn    (clkEn),
      .clear    (presClear),
      .divSel   (watchdogPrescaleSelect),
      .tick     (tick)
   );

   // prescaler restarts whenever the chip sits in reset
   assign presClear = (s.phase != wdr_pkg::PH_RUN) || serviceStrobe;

   always_comb begin
      logic                pinLow;
      logic                selfMask;
      logic                pwrDnHigh;
      logic                swReq;
      logic                wdtOvf;
      wdr_pkg::wdr_flags_t setF;
      wdr_pkg::wdr_flags_t clrF;
      pinLow   = 1'b0;
      selfMask = 1'b0;
      pwrDnHigh = 1'b0;
      swReq    = 1'b0;
      wdtOvf   = 1'b0;
      setF     = '0;
      clrF     = '0;
      next_s   = s;

      // pins from outside the clock domain pass two flops
      next_s.rstSync1 = resetInputPinIn;
      next_s.rstSync2 = s.rstSync1;
      next_s.pwrDnSync1 = resetPowerDownPin;
      next_s.pwrDnSync2 = s.pwrDnSync1;

      pinLow    = !s.rstSync2;
      pwrDnHigh = s.pwrDnSync2;

      // our own drive of the reset input comes back through the syncs;
      // masking it for the sync depth keeps it from reading as a pin reset
      next_s.drvDly = {s.drvDly[1:0], s.pinOe};
      selfMask      = s.pinOe || (|s.drvDly);

      next_s.pinOut = 1'b0;

      case (s.phase)
         wdr_pkg::PH_RUN: begin
            swReq  = softwareResetStrobe;
            // a service in the overflow cycle still rescues the chip
            wdtOvf = s.running && tick && (s.count == `WDR_COUNT_MAX)
                     && !serviceStrobe;
            if (endOfInitStrobe) begin
               next_s.initDone = 1'b1;
               clrF            = '1;
            end
            if (disableStrobe && !s.initDone && !endOfInitStrobe) begin
               next_s.running = 1'b0;
            end
            if (serviceStrobe) begin
               next_s.count = reloadValue(watchdogReloadByte);
            end else if (s.running && tick) begin
               next_s.count = s.count + 16'h0001;
            end
            if (pinLow && !selfMask) begin
               next_s.phase  = wdr_pkg::PH_PINLOW;
               next_s.lowCnt = 11'h001;
            end else if (wdtOvf || swReq) begin
               next_s.phase   = wdr_pkg::PH_HOLD;
               next_s.holdCnt = 10'h000;
               setF.watchdog  = wdtOvf;
               setF.software  = swReq;
               // low power-down pin blocks the bidirectional drive
               next_s.pinOe   = bidirectionalResetEnable && pwrDnHigh;
            end
         end
         wdr_pkg::PH_HOLD: begin
            next_s.holdCnt = s.holdCnt + 10'h001;
            if (s.holdCnt == 10'(`WDR_HOLD_CYC - 1)) begin
               next_s.phase = wdr_pkg::PH_RUN;
               next_s.pinOe = 1'b0;
            end
         end
         wdr_pkg::PH_PINLOW: begin
            if (pinLow) begin
               if (s.lowCnt != 11'h7ff) begin
                  next_s.lowCnt = s.lowCnt + 11'h001;
               end
            end else begin
               // low power-down pin gives an asynchronous reset with no flag
               setF = classifyPulse(s.lowCnt, pwrDnHigh);
               next_s.phase = wdr_pkg::PH_RUN;
            end
         end
         default: begin
            next_s.phase = wdr_pkg::PH_RUN;
         end
      endcase

      // chip reset state: counter restarts enabled when reset ends
      if (next_s.phase != wdr_pkg::PH_RUN) begin
         next_s.count    = `WDR_COUNT_RESET;
         next_s.running  = 1'b1;
         next_s.initDone = 1'b0;
      end

      // a new source wins over a clear in the same cycle
      next_s.flags = (s.flags & ~clrF) | setF;

      next_s.chipReset = (next_s.phase != wdr_pkg::PH_RUN);
      next_s.outN      = (next_s.phase == wdr_pkg::PH_RUN);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s               <= '0;
         s.phase         <= wdr_pkg::PH_RUN;
         s.count         <= `WDR_COUNT_RESET;
         s.running       <= 1'b1;
         s.flags.powerOn <= 1'b1;
         s.rstSync1      <= 1'b1;
         s.rstSync2      <= 1'b1;
         s.chipReset     <= 1'b1;
      end else if (clkEn) begin
         s <= next_s;
      end
   end

   assign resetInputPinOut   = s.pinOut;
   assign resetInputPinOe    = s.pinOe;
   assign resetOutputPinN    = s.outN;
   assign chipReset          = s.chipReset;
   assign watchdogCount      = s.count;
   assign watchdogRunning    = s.running;
   assign initDone           = s.initDone;
   assign watchdogControlReg = s.flags;

endmodule : wdr_watchdog

/* File: testbench/wdr_watchdog_asserts.sv */
`timescale 1ns/1ns
module wdr_watchdog_asserts (
   input wire logic                core_clk,                 // clock
   input wire logic                rst_n,                    // reset
   input wire logic                clkEn,                    // run enable
   input wire logic                resetInputPinOe,          // pin drive
   input wire logic                resetPowerDownPin,        // power-down pin
   input wire logic                bidirectionalResetEnable, // bidir enable
   input wire logic [7:0]          watchdogReloadByte,       // reload
   input wire logic                serviceStrobe,            // service
   input wire logic                disableStrobe,            // disable
   input wire logic                endOfInitStrobe,          // end of init
   input wire logic                softwareResetStrobe,      // sw reset
   input wire logic                resetOutputPinN,          // reset out
   input wire logic                chipReset,                // internal reset
   input wire logic [15:0]         watchdogCount,            // counter
   input wire logic                watchdogRunning,          // enabled
   input wire logic                initDone,                 // init done
   input wire wdr_pkg::wdr_flags_t watchdogControlReg        // flags
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic [9:0] holdLen;
   logic       swHold;
   sequence swAccept;
      softwareResetStrobe && clkEn && !chipReset;
   endsequence
   sequence wrapStep;
      !chipReset && watchdogCount == 16'hffff && !serviceStrobe && !softwareResetStrobe
         ##1 watchdogCount == 16'h0000;
   endsequence
   // swHold marks a hold entered from the sw reset, so pin resets do not skew the length
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         holdLen <= 10'h000;
         swHold  <= 1'b0;
      end else begin
         holdLen <= chipReset ? holdLen + 10'h001 : 10'h000;
         swHold  <= (softwareResetStrobe && clkEn && !chipReset) || (swHold && chipReset);
      end
   end
   a_run_release: assert property ($fell(chipReset) |-> watchdogRunning && !initDone)
      else $error("watchdog idle after reset");
   a_disable_locked: assert property (initDone && disableStrobe && clkEn && !chipReset &&
      watchdogRunning |=> watchdogRunning) else $error("disable taken after init");
   a_wrap_reset: assert property (wrapStep |-> chipReset && !resetOutputPinN &&
      watchdogControlReg.watchdog) else $error("overflow gave no reset");
   a_sw_reset: assert property (swAccept |=> chipReset && watchdogControlReg.software)
      else $error("sw reset missing");
   a_sw_drive: assert property (swAccept |=> resetInputPinOe ==
      ($past(bidirectionalResetEnable) && $past(resetPowerDownPin, 3)))
      else $error("pin drive wrong");
   a_service_reload: assert property (serviceStrobe && clkEn && !chipReset &&
      !softwareResetStrobe |=> watchdogCount == {$past(watchdogReloadByte), 8'h00})
      else $error("reload wrong");
   a_init_clear: assert property (endOfInitStrobe && clkEn && !chipReset &&
      !softwareResetStrobe && watchdogCount != 16'hffff |=> initDone && watchdogControlReg == 5'h00)
      else $error("flags not cleared");
   a_hold_len: assert property ($fell(chipReset) && swHold |-> holdLen == 10'h204)
      else $error("hold length wrong");
endmodule : wdr_watchdog_asserts

bind wdr_watchdog wdr_watchdog_asserts chk_u (.core_clk, .rst_n, .clkEn, .resetInputPinOe,
   .resetPowerDownPin, .bidirectionalResetEnable, .watchdogReloadByte, .serviceStrobe,
   .disableStrobe, .endOfInitStrobe, .softwareResetStrobe, .resetOutputPinN, .chipReset,
   .watchdogCount, .watchdogRunning, .initDone, .watchdogControlReg);

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   logic core_clk, rst_n, clkEn, pinDrv, pwrDn, bidir, sel, pinOut, pinOe, outN, chipReset;
   logic running, initDone;
   logic [7:0]          reload;
   logic [3:0]          strb; // service, disable, end of init, sw reset
   logic [15:0]         cnt, a;
   wdr_pkg::wdr_flags_t flags;
   int                  errors, n_checks, cyc, k;
   wire logic           pinWire = (pinOe && !pinOut) ? 1'b0 : pinDrv;
   wdr_watchdog dut_u (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
      .resetInputPinIn(pinWire), .resetInputPinOut(pinOut), .resetInputPinOe(pinOe),
      .resetPowerDownPin(pwrDn), .bidirectionalResetEnable(bidir), .watchdogPrescaleSelect(sel),
      .watchdogReloadByte(reload), .serviceStrobe(strb[0]), .disableStrobe(strb[1]),
      .endOfInitStrobe(strb[2]), .softwareResetStrobe(strb[3]), .resetOutputPinN(outN),
      .chipReset(chipReset), .watchdogCount(cnt), .watchdogRunning(running),
      .initDone(initDone), .watchdogControlReg(flags));
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task conclude;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick
   // one-cycle pulse; returns at the negedge after the capturing edge
   task strobe(input int i);
      strb[i] = 1'b1;
      tick(1);
      strb[i] = 1'b0;
   endtask : strobe
   task waitr(input logic lv);
      cyc = 0;
      while (chipReset !== lv && cyc < 2000) begin
         tick(1);
         cyc++;
      end
      chk("reset wait", 16'(cyc < 2000), 16'h0001);
   endtask : waitr
   task t_reset;
      chk("flags", 16'(flags), 16'h0010);
      chk("running", 16'(running), 16'h0001);
      chk("outN", 16'(outN), 16'h0001);
      $display("t_reset done");
   endtask : t_reset
   task t_disable;
      strobe(1);
      chk("disabled", 16'(running), 16'h0000);
      reload = 8'h12;
      strobe(0);
      chk("reload", cnt, 16'h1200);
      tick(300);
      chk("frozen", cnt, 16'h1200);
      reload = 8'h00;
      $display("t_disable done");
   endtask : t_disable
   task t_swreset;
      for (k = 0; k < 2; k++) begin
         pwrDn = k[0];
         tick(3);
         strobe(3);
         chk("sw flag", 16'(flags.software), 16'h0001);
         chk("pin oe", 16'(pinOe), 16'(k));
         chk("pin out", 16'(pinOut), 16'h0000);
         chk("outN low", 16'(outN), 16'h0000);
         waitr(1'b0);
         chk("rerun", 16'(running), 16'h0001);
      end
      $display("t_swreset done");
   endtask : t_swreset
   task t_eoi;
      strobe(2);
      chk("cleared", 16'(flags), 16'h0000);
      chk("init", 16'(initDone), 16'h0001);
      strobe(1);
      chk("still on", 16'(running), 16'h0001);
      $display("t_eoi done");
   endtask : t_eoi
   task t_divide;
      sel = 1'b0;
      reload = 8'hff;
      strobe(0);
      chk("reload ff", cnt, 16'hff00);
      a = cnt;
      tick(20);
      chk("div2", cnt - a, 16'h000a);
      clkEn = 1'b0;
      tick(10);
      chk("clk en hold", cnt, 16'hff0a);
      clkEn = 1'b1;
      sel = 1'b1;
      strobe(0);
      a = cnt;
      tick(256);
      chk("div128", cnt - a, 16'h0002);
      $display("t_divide done");
   endtask : t_divide
   task t_overflow;
      sel = 1'b0;
      strobe(0);
      waitr(1'b1);
      chk("timeout", 16'(cyc >= 510 && cyc <= 516), 16'h0001);
      chk("wdt flag", 16'(flags.watchdog), 16'h0001);
      chk("outN wdt", 16'(outN), 16'h0000);
      waitr(1'b0);
      chk("restart", 16'({running, initDone}), 16'h0002);
      sel = 1'b1;
      reload = 8'h00;
      $display("t_overflow done");
   endtask : t_overflow
   task t_pin(input int len, input logic [1:0] exp);
      strobe(2);
      pinDrv = 1'b0;
      tick(len);
      chk("pin held", 16'({chipReset, outN}), 16'h0002);
      pinDrv = 1'b1;
      waitr(1'b0);
      chk("pulse flags", 16'({flags.longHw, flags.shortHw}), 16'(exp));
      $display("t_pin done");
   endtask : t_pin
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      tick(20000);
      errors++;
      conclude();
   end
   initial begin
      {rst_n, strb, sel, reload} = 14'h0100;
      {clkEn, pinDrv, pwrDn, bidir} = 4'hf;
      tick(2);
      rst_n = 1'b1;
      tick(2);
      t_reset();
      t_disable();
      t_swreset();
      t_eoi();
      t_divide();
      t_overflow();
      t_pin(30, 2'b00);
      t_pin(100, 2'b01);
      t_pin(700, 2'b10);
      // power-down pin low: asynchronous hardware reset, no flag
      pwrDn = 1'b0;
      t_pin(100, 2'b00);
      pwrDn = 1'b1;
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      tick(2);
      t_reset();
      conclude();
   end
endmodule : tb_top
